// file: logic/echo_channel_control_combiner.v
// Per-channel control combiner with Avalon-MM register access.
`include "echo_ctrl_defs.vh"

module echo_channel_control_combiner (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire [9:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  input  wire        i_canceller_off_pin,
  input  wire        i_proc_bypass_pin,
  input  wire        i_hold_pin,
  input  wire        i_law_conversion_off_pin,
  input  wire        i_clear_channel_pin,
  input  wire        i_flexible_control_pin,
  input  wire        i_slot_strobe,
  input  wire [4:0]  i_slot_index,
  input  wire        i_frame_start,
  input  wire [31:0] i_ucc_conv_off,
  input  wire [31:0] i_ucc_hold,
  input  wire [31:0] i_ucc_proc_bypass,
  input  wire [31:0] i_ucc_path_bypass,
  input  wire [31:0] i_signalling_conv_off,
  input  wire [31:0] i_idle_detect,
  input  wire [31:0] i_scu_hold,
  input  wire [31:0] i_scu_proc_bypass,
  input  wire [31:0] i_scu_path_bypass,
  input  wire        i_per_channel_law_enable,
  input  wire [2:0]  i_global_law,
  output wire [31:0] o_path_bypass,
  output wire [31:0] o_proc_bypass,
  output wire [31:0] o_coef_hold,
  output wire [31:0] o_conv_off,
  output wire [31:0] o_coef_reset,
  output wire [31:0] o_scu_reset,
  output wire [31:0] o_meter_reset,
  output wire [31:0] o_near_law_alaw,
  output wire [31:0] o_far_law_alaw
);

  // Registers sit at word index; byte address is four times the index.
  function is_chan;
    input [7:0] idx;
    begin
      is_chan = (idx >= `IDX_CHAN_FIRST) && (idx <= `IDX_CHAN_LAST);
    end
  endfunction

  wire [7:0] reg_idx;
  wire       bus_req;
  reg        ack_ff;
  reg [31:0] rdata_ff;
  reg [5:0]  pin_mask_ff;
  reg [5:0]  flex_sel_ff;
  reg [7:0]  chan_ctrl_ff [0:31];

  assign reg_idx           = i_avs_address[9:2];
  assign bus_req           = i_avs_read | i_avs_write;
  // One wait state: the request completes on the second cycle.
  assign o_avs_waitrequest = bus_req & ~ack_ff;
  assign o_avs_readdata    = rdata_ff;

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // A write lands at the edge where waitrequest is seen low by the master.
  wire do_write;
  assign do_write = i_avs_write & ack_ff & i_avs_byteenable[0];

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (i_avs_read & ~ack_ff) begin
      if (is_chan(reg_idx)) begin
        rdata_ff <= {24'h000000, chan_ctrl_ff[reg_idx[4:0]]};
      end else if (reg_idx == `IDX_PIN_MASK) begin
        rdata_ff <= {26'h0, pin_mask_ff};
      end else if (reg_idx == `IDX_FLEX_SEL) begin
        rdata_ff <= {26'h0, flex_sel_ff};
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_mask_ff <= `RST_PIN_MASK;
      flex_sel_ff <= `RST_FLEX_SEL;
    end else if (do_write) begin
      if (reg_idx == `IDX_PIN_MASK) begin
        pin_mask_ff <= i_avs_writedata[5:0];
      end
      if (reg_idx == `IDX_FLEX_SEL) begin
        flex_sel_ff <= i_avs_writedata[5:0];
      end
    end
  end

  // Pins come from outside the clock domain: two flops before use.
  reg [5:0] pin_meta_ff;
  reg [5:0] pin_sync_ff;

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_meta_ff <= 6'h00;
      pin_sync_ff <= 6'h00;
    end else begin
      pin_meta_ff <= {i_canceller_off_pin, i_proc_bypass_pin, i_hold_pin,
                      i_law_conversion_off_pin, i_clear_channel_pin,
                      i_flexible_control_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Sampled pin levels per channel, latched in that channel's timeslot.
  reg [5:0]  pin_lat_ff   [0:31];
  reg [31:0] path_byp_ff;
  reg [31:0] proc_byp_ff;
  reg [31:0] hold_ff;
  reg [31:0] conv_off_ff;
  reg [31:0] coef_rst_ff;
  reg [31:0] scu_rst_ff;
  reg [31:0] meter_rst_ff;
  reg [31:0] near_law_ff;
  reg [31:0] far_law_ff;

  assign o_path_bypass   = path_byp_ff;
  assign o_proc_bypass   = proc_byp_ff;
  assign o_coef_hold     = hold_ff;
  assign o_conv_off      = conv_off_ff;
  assign o_coef_reset    = coef_rst_ff;
  assign o_scu_reset     = scu_rst_ff;
  assign o_meter_reset   = meter_rst_ff;
  assign o_near_law_alaw = near_law_ff;
  assign o_far_law_alaw  = far_law_ff;

  genvar c;
  generate
    for (c = 0; c < `NUM_CHAN; c = c + 1) begin : g_chan
      wire [7:0] ctl;
      wire [5:0] pin;
      wire       ext_on;
      wire       flex;
      wire       clr_ch;
      wire       ext_byp;
      wire       ext_proc;
      wire       ext_hold;
      wire       ext_conv;
      wire       ext_coef;
      wire       ext_meter;
      wire       conv_now;
      wire [2:0] law_sel;

      assign ctl = chan_ctrl_ff[c];

      always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          chan_ctrl_ff[c] <= `RST_CHAN_CTRL;
        end else if (do_write && is_chan(reg_idx)
                     && reg_idx[4:0] == c) begin
          chan_ctrl_ff[c] <= i_avs_writedata[7:0];
        end
      end

      always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          pin_lat_ff[c] <= 6'h00;
        end else if (i_slot_strobe && i_slot_index == c) begin
          pin_lat_ff[c] <= pin_sync_ff;
        end
      end

      // A set mask bit ignores the pin.
      assign pin    = pin_lat_ff[c] & ~pin_mask_ff;
      // Exclusive control shuts out pins and in-band requests; speech control unit inputs still pass.
      assign ext_on = ~ctl[`CH_EXCL];
      assign flex   = pin[`MSK_FLEX];
      assign clr_ch = pin[`MSK_CLEAR_CH];

      assign ext_byp = pin[`MSK_CANC_OFF] | clr_ch
                       | (flex & flex_sel_ff[`FS_PATH_BYP])
                       | i_ucc_path_bypass[c] | i_idle_detect[c];
      assign ext_proc = pin[`MSK_PROC_BYP]
                        | (flex & flex_sel_ff[`FS_PROC_OFF])
                        | i_ucc_proc_bypass[c];
      assign ext_hold = pin[`MSK_HOLD]
                        | (flex & flex_sel_ff[`FS_HOLD])
                        | i_ucc_hold[c];
      assign ext_conv = pin[`MSK_CONV_OFF] | clr_ch
                        | (flex & flex_sel_ff[`FS_CONV_OFF])
                        | i_ucc_conv_off[c] | i_signalling_conv_off[c];
      assign ext_coef = (flex & flex_sel_ff[`FS_COEF_RST])
                        | i_idle_detect[c];
      assign ext_meter = flex & flex_sel_ff[`FS_METER_RST];

      // Register bits ORed with outside requests when not exclusive.
      assign conv_now = ctl[`CH_CONV_OFF] | (ext_on & ext_conv);
      assign law_sel  = i_per_channel_law_enable ? ctl[7:5] : i_global_law;

      always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          path_byp_ff[c]  <= 1'b0;
          proc_byp_ff[c]  <= 1'b0;
          hold_ff[c]      <= 1'b0;
          conv_off_ff[c]  <= 1'b0;
          coef_rst_ff[c]  <= 1'b0;
          scu_rst_ff[c]   <= 1'b0;
          meter_rst_ff[c] <= 1'b0;
          near_law_ff[c]  <= 1'b0;
          far_law_ff[c]   <= 1'b0;
        end else if (i_frame_start) begin
          path_byp_ff[c] <= ctl[`CH_CANC_OFF] | i_scu_path_bypass[c]
                            | (ext_on & ext_byp);
          proc_byp_ff[c] <= ctl[`CH_PROC_BYP] | i_scu_proc_bypass[c]
                            | (ext_on & ext_proc);
          hold_ff[c]     <= ctl[`CH_HOLD] | i_scu_hold[c]
                            | (ext_on & ext_hold);
          conv_off_ff[c] <= conv_now;
          coef_rst_ff[c] <= ctl[`CH_CANC_OFF]
                            | (ext_on & ext_coef);
          scu_rst_ff[c]  <= ctl[`CH_CANC_OFF]
                            | (ext_on & i_idle_detect[c]);
          meter_rst_ff[c] <= ext_on & ext_meter;
          // Disabled conversion forces the disabled-law code both ways.
          near_law_ff[c] <= conv_now ? law_sel[2] : law_sel[1];
          far_law_ff[c]  <= conv_now ? law_sel[2] : law_sel[0];
        end
      end
    end
  endgenerate

endmodule // echo_channel_control_combiner

// file: logic/echo_ctrl_defs.vh
// Constants for the per-channel echo canceller control combiner.
`ifndef ECHO_CTRL_DEFS_VH
`define ECHO_CTRL_DEFS_VH

`define NUM_CHAN           32
`define IDX_CHAN_FIRST     8'h40
`define IDX_CHAN_LAST      8'h5F
`define IDX_PIN_MASK       8'h6B
`define IDX_FLEX_SEL       8'h6C
`define RST_PIN_MASK       6'h3F
`define RST_FLEX_SEL       6'h00
`define RST_CHAN_CTRL      8'h00

`define CH_DIS_LAW         7
`define CH_NEAR_LAW        6
`define CH_FAR_LAW         5
`define CH_CONV_OFF        4
`define CH_HOLD            3
`define CH_PROC_BYP        2
`define CH_CANC_OFF        1
`define CH_EXCL            0

`define MSK_CANC_OFF       5
`define MSK_PROC_BYP       4
`define MSK_HOLD           3
`define MSK_CONV_OFF       2
`define MSK_CLEAR_CH       1
`define MSK_FLEX           0

`define FS_PATH_BYP        5
`define FS_PROC_OFF        4
`define FS_HOLD            3
`define FS_METER_RST       2
`define FS_COEF_RST        1
`define FS_CONV_OFF        0

`endif

// file: bench/echo_ctrl_asserts.sv
// Port-level assertions for the echo channel control combiner.
module echo_ctrl_asserts (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire        i_frame_start,
  input wire [31:0] i_scu_hold,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire [31:0] o_path_bypass,
  input wire [31:0] o_coef_hold,
  input wire [31:0] o_conv_off,
  input wire [31:0] o_near_law_alaw,
  input wire [31:0] o_far_law_alaw
);
  wire req = i_avs_read | i_avs_write;
  wire ack = req & !o_avs_waitrequest;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_one_wait: assert property ($rose(req) |->
    o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait state");
  a_idle_ready: assert property (!req |-> !o_avs_waitrequest)
    else $error("wait while idle");
  a_upper_zero: assert property (i_avs_read && ack |->
    o_avs_readdata[31:8] == 24'h0) else $error("upper read bits");
  a_read_hold: assert property (i_avs_read && ack |=>
    $stable(o_avs_readdata)) else $error("read data moved");
  a_frame_only: assert property (!i_frame_start |=>
    $stable(o_path_bypass) && $stable(o_coef_hold)) else $error("no frame");
  a_scu_hold: assert property (i_frame_start |=>
    (o_coef_hold & $past(i_scu_hold)) == $past(i_scu_hold))
    else $error("speech unit hold lost");
  a_conv_law: assert property (
    (o_conv_off & (o_near_law_alaw ^ o_far_law_alaw)) == 32'h0)
    else $error("law split while conversion off");
  a_reset_clear: assert property ($rose(i_rst_n) |->
    o_path_bypass == 32'h0 && o_avs_readdata == 32'h0)
    else $error("outputs not cleared");
  c_path: cover property (i_frame_start && |o_path_bypass);
  c_read: cover property (i_avs_read && ack);
  c_hold: cover property (i_frame_start && |o_coef_hold);
endmodule // echo_ctrl_asserts

bind echo_channel_control_combiner echo_ctrl_asserts u_chk (.i_clk_sys,
  .i_rst_n, .i_avs_read, .i_avs_write, .i_frame_start, .i_scu_hold,
  .o_avs_readdata, .o_avs_waitrequest, .o_path_bypass, .o_coef_hold,
  .o_conv_off, .o_near_law_alaw, .o_far_law_alaw);

// file: bench/pin_drive_model.sv
// Serial control pin driver and timeslot sequencer model.
module pin_drive_model (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire  [4:0] i_chan,
  input  wire  [5:0] i_req,
  output logic [5:0] o_pins,
  output logic       o_slot_strobe,
  output logic [4:0] o_slot_index,
  output logic       o_frame_start
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt_ff = 7'h00;
  always @(posedge i_clk_sys) begin
    cnt_ff <= i_rst_n ? cnt_ff + 7'h01 : 7'h00;
  end
  // Pins rise at slot start so the two sync flops settle before the strobe.
  assign o_pins = (cnt_ff[6:2] == i_chan) ? i_req : 6'h00;
  assign o_slot_strobe = (cnt_ff[1:0] == 2'h3);
  assign o_slot_index = cnt_ff[6:2];
  assign o_frame_start = (cnt_ff == 7'h7F);
endmodule // pin_drive_model

// file: bench/echo_channel_control_combiner_bench.sv
// Self-checking bench for the echo channel control combiner.
module echo_channel_control_combiner_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        lawen = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wd = 32'h0, in_band_user_control = 32'h0, speech_control_unit = 32'h0, q;
  logic [5:0]  req = 6'h00, pins;
  logic [4:0]  chan = 5'h00, six;
  logic        stb, fs, wt;
  logic [31:0] rdat, pbv, nbv, hov, cov, crv, srv, mrv, nlv, flv;
  int          err_count = 0, tests_run = 0, cyc = 0;
  always #10 clk = ~clk;
  pin_drive_model u_pins (.i_clk_sys(clk), .i_rst_n(rst_n), .i_chan(chan),
    .i_req(req), .o_pins(pins), .o_slot_strobe(stb), .o_slot_index(six),
    .o_frame_start(fs));
  echo_channel_control_combiner dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt), .i_canceller_off_pin(pins[5]),
    .i_proc_bypass_pin(pins[4]), .i_hold_pin(pins[3]),
    .i_law_conversion_off_pin(pins[2]), .i_clear_channel_pin(pins[1]),
    .i_flexible_control_pin(pins[0]), .i_slot_strobe(stb),
    .i_slot_index(six), .i_frame_start(fs), .i_ucc_conv_off(in_band_user_control),
    .i_ucc_hold(in_band_user_control), .i_ucc_proc_bypass(in_band_user_control), .i_ucc_path_bypass(in_band_user_control),
    .i_signalling_conv_off(in_band_user_control), .i_idle_detect(in_band_user_control), .i_scu_hold(speech_control_unit),
    .i_scu_proc_bypass(speech_control_unit), .i_scu_path_bypass(speech_control_unit),
    .i_per_channel_law_enable(lawen), .i_global_law(3'h0),
    .o_path_bypass(pbv), .o_proc_bypass(nbv), .o_coef_hold(hov),
    .o_conv_off(cov), .o_coef_reset(crv), .o_scu_reset(srv),
    .o_meter_reset(mrv), .o_near_law_alaw(nlv), .o_far_law_alaw(flv));
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    adr <= {i, 2'h0};
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task fr;
    repeat (3) @(posedge clk iff fs);
    @(posedge clk);
  endtask
  function automatic logic pick(input int b);
    case (b)
      5: return pbv[9];
      4: return nbv[9];
      3: return hov[9];
      2: return mrv[9];
      1: return crv[9];
      default: return cov[9];
    endcase
  endfunction
  task t_reset;
    rc(8'h6B, 8'h3F);
    rc(8'h6C, 8'h00);
    rc(8'h40, 8'h00);
    rc(8'h60, 8'h00);
    bus(1'b1, 8'h5F, 8'hA5);
    rc(8'h5F, 8'hA5);
    bus(1'b1, 8'h5F, 8'h00);
    $display("reset test done");
  endtask
  task t_regs;
    logic [7:0] v[4];
    v = '{8'h08, 8'h04, 8'h02, 8'h90};
    lawen <= 1'b1;
    for (int k = 0; k < 4; k++) bus(1'b1, 8'(8'h41 + k), v[k]);
    fr;
    chk({hov, nbv}, {32'h2, 32'h4});
    chk({pbv, srv}, {32'h8, 32'h8});
    chk({crv, cov}, {32'h8, 32'h10});
    chk({nlv, flv}, {32'h10, 32'h10});
    for (int k = 0; k < 4; k++) bus(1'b1, 8'(8'h41 + k), 8'h00);
    $display("register test done");
  endtask
  task t_excl;
    bus(1'b1, 8'h6B, 8'h00);
    bus(1'b1, 8'h45, 8'h01);
    in_band_user_control <= '1;
    chan <= 5'd5;
    req <= 6'h3F;
    fr;
    chk({pbv[5], nbv[5], hov[5], cov[5], crv[5], srv[5]}, 0);
    chk({pbv[6], hov[6], cov[6]}, 3'h7);
    in_band_user_control <= '0;
    req <= 6'h00;
    speech_control_unit <= 32'h20;
    fr;
    chk({pbv[5], nbv[5], hov[5]}, 3'h7);
    speech_control_unit <= '0;
    bus(1'b1, 8'h45, 8'h00);
    $display("exclusive test done");
  endtask
  task t_pins;
    chan <= 5'd9;
    for (int p = 0; p < 2; p++)
      for (int b = 3 * p; b < 6; b++)
        for (int m = 0; m < 2; m++) begin
          bus(1'b1, 8'h6B, m ? (p ? 8'h01 << b : 8'h01) : 8'h00);
          bus(1'b1, 8'h6C, p ? 8'h00 : 8'h01 << b);
          req <= p ? 6'h01 << b : 6'h01;
          fr;
          chk(pick(b), !m);
        end
    $display("pin test done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_excl;
    t_pins;
    stop_test;
  end
endmodule // echo_channel_control_combiner_bench
